/* rtl/dbu_top.v */
// Behaviour
// - Sample tick every divisor clocks, bit sixteen
// - Divisor zero stops receiver and transmitter
// - Receiver off at reset, enable starts hunting
// - Receiver disable waits for character end
// - Receiver reset drops character immediately
// - Start bit needs more than seven samples
// - First sample at 24, then every 16
// - Completed character sets ready, read clears
// - Overrun when ready still set, sticky
// - Parity mismatch flag, sticky until clear
// - Low stop bit sets framing flag
// - Transmitter off at reset, waits holding write
// - Transmitter disable finishes both characters
// - Transmitter reset stops at once
// - Start, eight data LSB first, parity, stop
// - Transmit ready while enabled and holding empty
// - Transmit empty after final stop bit
// - Ready flags request DMA, channels at 0x100; no channel registers here, that window reads zero
// - Echo copies receive pin to transmit pin
// - Local loopback feeds transmitter to receiver
// - Remote loopback wires pins, both halves idle
// - Parity codes zero-three, top bit none
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "dbu_defs.vh"

module dbu_top
(
	input  wire        i_clk_sys,
	input  wire        i_resetn,
	input  wire [8:0]  i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] i_avs_writedata,
	input  wire [3:0]  i_avs_byteenable,
	output reg  [31:0] o_avs_readdata,
	output reg         o_avs_waitrequest,
	input  wire        i_serial_rx_pin,
	output reg         o_serial_tx_pin,
	output reg         o_rx_dma_req,
	output reg         o_tx_dma_req
);

localparam RX_OFF  = 3'h1;
localparam RX_HUNT = 3'h2;
localparam RX_BITS = 3'h4;

// ==========================================
// Bus slave
wire        acc;
wire        acc_wr;
wire        acc_rd;
wire [31:0] wmask;
wire [31:0] wdat;
reg  [31:0] rd_nxt;

assign acc    = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
assign acc_wr = acc && i_avs_write;
assign acc_rd = acc && i_avs_read;
assign wmask  = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
	{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
assign wdat   = i_avs_writedata & wmask;

// Every access costs two cycles; effects land on the completing edge
always @(posedge i_clk_sys or negedge i_resetn)
begin
	if (!i_resetn)
	begin
		o_avs_waitrequest <= 1'h1;
		o_avs_readdata    <= 32'h0;
	end
	else if (acc)
		o_avs_waitrequest <= 1'h1;
	else if (i_avs_read || i_avs_write)
	begin
		o_avs_waitrequest <= 1'h0;
		o_avs_readdata    <= i_avs_read ? rd_nxt : 32'h0;
	end
end

// ==========================================
// Command decode
wire wr_cmd;
wire rx_rst;
wire rx_on;
wire rx_off;
wire tx_rst;
wire tx_on;
wire tx_off;
wire err_clr;
wire wr_txh;
wire rd_rxh;

assign wr_cmd  = acc_wr && i_avs_address == `DBU_OFS_CMD;
assign rx_rst  = wr_cmd && wdat[`DBU_CMD_RX_RST];
assign rx_off  = wr_cmd && wdat[`DBU_CMD_RX_OFF];
assign rx_on   = wr_cmd && wdat[`DBU_CMD_RX_ON] && !rx_off;
assign tx_rst  = wr_cmd && wdat[`DBU_CMD_TX_RST];
assign tx_off  = wr_cmd && wdat[`DBU_CMD_TX_OFF];
assign tx_on   = wr_cmd && wdat[`DBU_CMD_TX_ON] && !tx_off;
assign err_clr = wr_cmd && wdat[`DBU_CMD_ERR_CLR];
assign wr_txh  = acc_wr && i_avs_address == `DBU_OFS_TXH && i_avs_byteenable[0];
assign rd_rxh  = acc_rd && i_avs_address == `DBU_OFS_RXH;

// ==========================================
// Format and divisor registers
reg  [31:0] fmt_r;
reg  [15:0] clock_divisor_r;
wire [2:0]  parity_type;
wire [1:0]  channel_test_mode;
wire        par_on;

assign parity_type       = fmt_r[`DBU_FMT_PAR_LSB +: 3];
assign channel_test_mode = fmt_r[`DBU_FMT_MODE_LSB +: 2];
// top code bit means no parity
assign par_on            = !parity_type[2];

always @(posedge i_clk_sys or negedge i_resetn)
begin
	if (!i_resetn)
	begin
		fmt_r           <= `DBU_FMT_RST;
		clock_divisor_r <= `DBU_DIV_RST;
	end
	else if (acc_wr)
	begin
		if (i_avs_address == `DBU_OFS_FMT)
			fmt_r <= ((fmt_r & ~wmask) | wdat) & 32'h0000_ce00;
		if (i_avs_address == `DBU_OFS_DIV)
			clock_divisor_r <= (clock_divisor_r & ~wmask[15:0]) | wdat[15:0];
	end
end

// ==========================================
// Sampling tick divider
reg  [15:0] div_cnt_r;
reg         tick_r;
wire        div_on;
wire        rx_ok;
wire        tx_ok;

assign div_on = clock_divisor_r != 16'h0;
assign rx_ok  = div_on && channel_test_mode != `DBU_MODE_REMOTE;
assign tx_ok  = div_on && channel_test_mode != `DBU_MODE_REMOTE;

always @(posedge i_clk_sys or negedge i_resetn)
begin
	if (!i_resetn)
	begin
		div_cnt_r <= 16'h0;
		tick_r    <= 1'h0;
	end
	else if (!div_on)
	begin
		div_cnt_r <= 16'h0;
		tick_r    <= 1'h0;
	end
	else if (div_cnt_r >= clock_divisor_r - 16'h1)
	begin
		div_cnt_r <= 16'h0;
		tick_r    <= 1'h1;
	end
	else
	begin
		div_cnt_r <= div_cnt_r + 16'h1;
		tick_r    <= 1'h0;
	end
end

// ==========================================
// Receiver
reg  [2:0] rx_st_r;
reg  [3:0] low_cnt_r;
reg  [4:0] gap_r;
reg  [3:0] bit_idx_r;
reg  [7:0] rx_data_r;
reg        rx_parb_r;
reg        rx_stop_pend_r;
reg  [7:0] rxh_r;
reg        rx_char_avail_r;
reg        rx_overrun_flag_r;
reg        frame_r;
reg        parity_err_flag_r;
wire       tx_line;
wire       rx_line;
wire       rx_tick;
wire [3:0] last_idx;
wire       rx_done;
wire       rx_exp_par;

assign rx_line  = channel_test_mode == `DBU_MODE_LOCAL ? tx_line : i_serial_rx_pin;
assign rx_tick  = tick_r && rx_ok;
assign last_idx = par_on ? 4'h9 : 4'h8;
assign rx_done  = rx_st_r == RX_BITS && rx_tick && gap_r == 5'h1
	&& bit_idx_r == last_idx && !rx_rst;

dbu_par u_rx_par
(
	.i_data (rx_data_r),
	.i_type (parity_type),
	.o_bit  (rx_exp_par)
);

always @(posedge i_clk_sys or negedge i_resetn)
begin
	if (!i_resetn)
	begin
		rx_st_r        <= RX_OFF;
		low_cnt_r      <= 4'h0;
		gap_r          <= 5'h0;
		bit_idx_r      <= 4'h0;
		rx_data_r      <= 8'h0;
		rx_parb_r      <= 1'h0;
		rx_stop_pend_r <= 1'h0;
	end
	else if (rx_rst)
	begin
		rx_st_r        <= RX_OFF;
		rx_stop_pend_r <= 1'h0;
	end
	else
	begin
		case (rx_st_r)
			RX_OFF:
			begin
				if (rx_on)
				begin
					rx_st_r   <= RX_HUNT;
					low_cnt_r <= 4'h0;
				end
			end
			RX_HUNT:
			begin
				if (rx_off)
					rx_st_r <= RX_OFF;
				else if (rx_tick)
				begin
					if (rx_line)
						low_cnt_r <= 4'h0;
					// eighth low sample is a start
					else if (low_cnt_r == `DBU_START_LOW)
					begin
						rx_st_r   <= RX_BITS;
						// first sample 24 after the edge
						gap_r     <= `DBU_FIRST_SAMPLE - {1'h0, `DBU_START_LOW};
						bit_idx_r <= 4'h0;
					end
					else
						low_cnt_r <= low_cnt_r + 4'h1;
				end
			end
			RX_BITS:
			begin
				if (rx_off)
					rx_stop_pend_r <= 1'h1;
				if (rx_tick)
				begin
					if (gap_r == 5'h1)
					begin
						gap_r     <= `DBU_OVS;
						bit_idx_r <= bit_idx_r + 4'h1;
						if (bit_idx_r < 4'h8)
							rx_data_r <= {rx_line, rx_data_r[7:1]};
						else if (bit_idx_r != last_idx)
							rx_parb_r <= rx_line;
						if (bit_idx_r == last_idx)
						begin
							rx_st_r        <= (rx_stop_pend_r || rx_off) ? RX_OFF : RX_HUNT;
							low_cnt_r      <= 4'h0;
							rx_stop_pend_r <= 1'h0;
						end
					end
					else
						gap_r <= gap_r - 5'h1;
				end
			end
			default:
				rx_st_r <= RX_OFF;
		endcase
	end
end

// Set beats clear when both land together
always @(posedge i_clk_sys or negedge i_resetn)
begin
	if (!i_resetn)
	begin
		rxh_r   <= 8'h0;
		rx_char_avail_r <= 1'h0;
		rx_overrun_flag_r  <= 1'h0;
		frame_r <= 1'h0;
		parity_err_flag_r  <= 1'h0;
	end
	else
	begin
		if (rx_done)
		begin
			rxh_r   <= rx_data_r;
			rx_char_avail_r <= 1'h1;
		end
		else if (rd_rxh)
			rx_char_avail_r <= 1'h0;
		if (rx_done && rx_char_avail_r && !rd_rxh)
			rx_overrun_flag_r <= 1'h1;
		else if (err_clr)
			rx_overrun_flag_r <= 1'h0;
		if (rx_done && !rx_line)
			frame_r <= 1'h1;
		else if (err_clr)
			frame_r <= 1'h0;
		if (rx_done && par_on && rx_parb_r != rx_exp_par)
			parity_err_flag_r <= 1'h1;
		else if (err_clr)
			parity_err_flag_r <= 1'h0;
	end
end

// ==========================================
// Transmitter control
reg        tx_en_r;
reg        tx_off_pend_r;
reg  [7:0] txh_r;
reg        txh_full_r;
wire       tx_busy;
wire       tx_go;
wire       tx_par_bit;
wire       tx_holding_free;
wire       tx_all_done;

// start only from a written holding register
assign tx_go   = tx_en_r && txh_full_r && !tx_busy && tx_ok && !tx_rst;
// ready while enabled and holding empty
assign tx_holding_free   = tx_en_r && !txh_full_r;
// empty once shifter and holding drain
assign tx_all_done = tx_en_r && !txh_full_r && !tx_busy;

dbu_par u_tx_par
(
	.i_data (txh_r),
	.i_type (parity_type),
	.o_bit  (tx_par_bit)
);

dbu_tx u_tx
(
	.i_clk_sys (i_clk_sys),
	.i_resetn  (i_resetn),
	.i_tick    (tick_r),
	.i_go      (tx_go),
	.i_data    (txh_r),
	.i_par_on  (par_on),
	.i_par_bit (tx_par_bit),
	.i_abort   (tx_rst),
	.o_line    (tx_line),
	.o_busy    (tx_busy)
);

always @(posedge i_clk_sys or negedge i_resetn)
begin
	if (!i_resetn)
	begin
		tx_en_r       <= 1'h0;
		tx_off_pend_r <= 1'h0;
		txh_r         <= 8'h0;
		txh_full_r    <= 1'h0;
	end
	else if (tx_rst)
	begin
		tx_en_r       <= 1'h0;
		tx_off_pend_r <= 1'h0;
		txh_full_r    <= 1'h0;
	end
	else
	begin
		if (tx_on)
			tx_en_r <= 1'h1;
		if (tx_off && !tx_busy && !txh_full_r)
			tx_en_r <= 1'h0;
		else if (tx_off)
			tx_off_pend_r <= 1'h1;
		else if (tx_off_pend_r && !tx_busy && !txh_full_r)
		begin
			tx_en_r       <= 1'h0;
			tx_off_pend_r <= 1'h0;
		end
		// Holding write may refill the slot freed this edge
		if (wr_txh)
		begin
			txh_r      <= i_avs_writedata[7:0];
			txh_full_r <= 1'h1;
		end
		else if (tx_go)
			txh_full_r <= 1'h0;
	end
end

// ==========================================
// Pin routing and request outputs
reg tx_pin_nxt;

always @*
begin
	case (channel_test_mode)
		`DBU_MODE_ECHO: tx_pin_nxt = i_serial_rx_pin;
		`DBU_MODE_LOCAL: tx_pin_nxt = 1'h1;
		`DBU_MODE_REMOTE: tx_pin_nxt = i_serial_rx_pin;
		default: tx_pin_nxt = tx_line;
	endcase
end

always @(posedge i_clk_sys or negedge i_resetn)
begin
	if (!i_resetn)
	begin
		o_serial_tx_pin <= 1'h1;
		o_rx_dma_req    <= 1'h0;
		o_tx_dma_req    <= 1'h0;
	end
	else
	begin
		o_serial_tx_pin <= tx_pin_nxt;
		o_rx_dma_req    <= rx_char_avail_r && !rd_rxh;
		o_tx_dma_req    <= tx_holding_free && !wr_txh;
	end
end

// ==========================================
// Read mux; DMA channel window reads zero
always @*
begin
	rd_nxt = 32'h0;
	case (i_avs_address)
		`DBU_OFS_FMT: rd_nxt = fmt_r;
		`DBU_OFS_DIV: rd_nxt = {16'h0, clock_divisor_r};
		`DBU_OFS_RXH: rd_nxt = {24'h0, rxh_r};
		`DBU_OFS_FLAG:
		begin
			rd_nxt[`DBU_FLAG_RX_CHAR_AVAIL]   = rx_char_avail_r;
			rd_nxt[`DBU_FLAG_TX_HOLDING_FREE]   = tx_holding_free;
			rd_nxt[`DBU_FLAG_RX_OVERRUN_FLAG]    = rx_overrun_flag_r;
			rd_nxt[`DBU_FLAG_FRAME]   = frame_r;
			rd_nxt[`DBU_FLAG_PARITY_ERR_FLAG]    = parity_err_flag_r;
			rd_nxt[`DBU_FLAG_TX_ALL_DONE] = tx_all_done;
		end
		default: rd_nxt = 32'h0;
	endcase
end

endmodule

/* rtl/dbu_defs.vh */
`ifndef DBU_DEFS_VH
`define DBU_DEFS_VH

// ==========================================
// Register byte offsets
`define DBU_OFS_CMD        9'h000
`define DBU_OFS_FMT        9'h004
`define DBU_OFS_FLAG       9'h014
`define DBU_OFS_RXH        9'h018
`define DBU_OFS_TXH        9'h01c
`define DBU_OFS_DIV        9'h020
`define DBU_OFS_DMA        9'h100

// ==========================================
// Command register bits
`define DBU_CMD_RX_RST     2
`define DBU_CMD_TX_RST     3
`define DBU_CMD_RX_ON      4
`define DBU_CMD_RX_OFF     5
`define DBU_CMD_TX_ON      6
`define DBU_CMD_TX_OFF     7
`define DBU_CMD_ERR_CLR    8

// ==========================================
// Format register fields
`define DBU_FMT_PAR_LSB    9
`define DBU_FMT_MODE_LSB   14
`define DBU_FMT_RST        32'h0000_0000
`define DBU_DIV_RST        16'h0000
`define DBU_MODE_NORMAL    2'h0
`define DBU_MODE_ECHO      2'h1
`define DBU_MODE_LOCAL     2'h2
`define DBU_MODE_REMOTE    2'h3

// ==========================================
// Flag register bits
`define DBU_FLAG_RX_CHAR_AVAIL     0
`define DBU_FLAG_TX_HOLDING_FREE     1
`define DBU_FLAG_RX_OVERRUN_FLAG      5
`define DBU_FLAG_FRAME     6
`define DBU_FLAG_PARITY_ERR_FLAG      7
`define DBU_FLAG_TX_ALL_DONE   9

// ==========================================
// Timing counts in sampling ticks
`define DBU_OVS            5'h10
`define DBU_START_LOW      4'h7
`define DBU_FIRST_SAMPLE   5'h18

`endif

/* rtl/dbu_par.v */
`timescale 1ns/1ps

// ==========================================
// Parity bit for one character
module dbu_par
(
	input  wire [7:0] i_data,
	input  wire [2:0] i_type,
	output reg        o_bit
);

always @*
begin
	case (i_type[1:0])
		2'h0: o_bit = ^i_data;
		2'h1: o_bit = ~^i_data;
		2'h2: o_bit = 1'h0;
		default: o_bit = 1'h1;
	endcase
end

endmodule

/* rtl/dbu_tx.v */
`timescale 1ns/1ps
`include "dbu_defs.vh"

// ==========================================
// Character shifter, one bit per 16 ticks
module dbu_tx
(
	input  wire       i_clk_sys,
	input  wire       i_resetn,
	input  wire       i_tick,
	input  wire       i_go,
	input  wire [7:0] i_data,
	input  wire       i_par_on,
	input  wire       i_par_bit,
	input  wire       i_abort,
	output reg        o_line,
	output reg        o_busy
);

reg [10:0] sh_r;
reg [3:0]  left_r;
reg [3:0]  sub_r;

always @(posedge i_clk_sys or negedge i_resetn)
begin
	if (!i_resetn)
	begin
		sh_r   <= 11'h7ff;
		left_r <= 4'h0;
		sub_r  <= 4'h0;
		o_busy <= 1'h0;
		o_line <= 1'h1;
	end
	else if (i_abort)
	begin
		o_busy <= 1'h0;
		o_line <= 1'h1;
	end
	else if (i_go)
	begin
		if (i_par_on)
		begin
			sh_r   <= {1'h1, i_par_bit, i_data, 1'h0};
			left_r <= 4'hb;
		end
		else
		begin
			sh_r   <= {2'h3, i_data, 1'h0};
			left_r <= 4'ha;
		end
		sub_r  <= 4'h0;
		o_busy <= 1'h1;
	end
	else if (o_busy && i_tick)
	begin
		if (sub_r == 4'h0)
		begin
			o_line <= sh_r[0];
			sh_r   <= {1'h1, sh_r[10:1]};
			left_r <= left_r - 4'h1;
		end
		sub_r <= sub_r + 4'h1;
		if ({1'h0, sub_r} == `DBU_OVS - 5'h1 && left_r == 4'h0)
			o_busy <= 1'h0;
	end
end

endmodule

/* bench/dbu_top_asserts.sv */
`timescale 1ns/1ps
`include "dbu_defs.vh"

// ==========================================
// Port checks
module dbu_top_chk
(
	input wire        i_clk_sys,
	input wire        i_resetn,
	input wire [8:0]  i_avs_address,
	input wire        i_avs_read,
	input wire        i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0]  i_avs_byteenable,
	input wire [31:0] o_avs_readdata,
	input wire        o_avs_waitrequest,
	input wire        i_serial_rx_pin,
	input wire        o_serial_tx_pin,
	input wire        o_rx_dma_req
);
	reg  [1:0]  mode_r;
	reg  [15:0] div_r;
	reg  [11:0] low_r;
	wire        wr_ok = i_avs_write && !o_avs_waitrequest;
	wire        rd_ok = i_avs_read && !o_avs_waitrequest;

	// Shadow of mode and divisor, seen only at completed writes
	always @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			mode_r <= 2'h0;
			div_r  <= 16'h0;
			low_r  <= 12'h0;
		end
		else
		begin
			if (wr_ok && i_avs_address == `DBU_OFS_FMT && i_avs_byteenable[1])
				mode_r <= i_avs_writedata[15:14];
			if (wr_ok && i_avs_address == `DBU_OFS_DIV)
				div_r <= i_avs_writedata[15:0];
			low_r <= o_serial_tx_pin ? 12'h0 : low_r + 12'h1;
		end
	end

	default clocking dc @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_resetn);

	a_wait_one: assert property (
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("Bus request not answered next cycle");
	a_wait_back: assert property (
		!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("Wait request low too long");
	a_reset_idle: assert property (
		$rose(i_resetn) |-> o_avs_waitrequest && o_serial_tx_pin && !o_rx_dma_req)
		else $error("Outputs not idle after reset");
	a_echo_copy: assert property (
		mode_r == `DBU_MODE_ECHO && $past(mode_r) == `DBU_MODE_ECHO
		|-> o_serial_tx_pin == $past(i_serial_rx_pin))
		else $error("Echo mode does not copy the line");
	a_remote_copy: assert property (
		mode_r == `DBU_MODE_REMOTE && $past(mode_r) == `DBU_MODE_REMOTE
		|-> o_serial_tx_pin == $past(i_serial_rx_pin))
		else $error("Remote loop does not copy the line");
	a_local_high: assert property (
		mode_r == `DBU_MODE_LOCAL && $past(mode_r) == `DBU_MODE_LOCAL |-> o_serial_tx_pin)
		else $error("Local loop drives the line");
	a_bit_len: assert property (
		$rose(o_serial_tx_pin) && div_r == 16'h1 && mode_r == `DBU_MODE_NORMAL
		|-> low_r[3:0] == 4'h0)
		else $error("Low run not whole bits");
	a_tx_rst_idle: assert property (
		wr_ok && i_avs_address == `DBU_OFS_CMD && i_avs_writedata[3]
		&& mode_r == `DBU_MODE_NORMAL |-> ##3 o_serial_tx_pin [*8])
		else $error("Line not idle after transmitter reset");
	a_rx_dma_clr: assert property (
		rd_ok && i_avs_address == `DBU_OFS_RXH |-> ##2 !o_rx_dma_req)
		else $error("Receive request stays after read");
	a_read_zero: assert property (
		rd_ok && (i_avs_address[8] || i_avs_address == `DBU_OFS_CMD)
		|-> o_avs_readdata == 32'h0)
		else $error("Unmapped read not zero");
endmodule

bind dbu_top dbu_top_chk chk_u
(
	.i_clk_sys        (i_clk_sys),
	.i_resetn         (i_resetn),
	.i_avs_address    (i_avs_address),
	.i_avs_read       (i_avs_read),
	.i_avs_write      (i_avs_write),
	.i_avs_writedata  (i_avs_writedata),
	.i_avs_byteenable (i_avs_byteenable),
	.o_avs_readdata   (o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest),
	.i_serial_rx_pin  (i_serial_rx_pin),
	.o_serial_tx_pin  (o_serial_tx_pin),
	.o_rx_dma_req     (o_rx_dma_req)
);

/* bench/dbu_host.sv */
`timescale 1ns/1ps

// ==========================================
// Far-end serial port, 16 clocks a bit
module dbu_host
(
	input  wire i_clk_sys,
	input  wire i_line,
	output reg  o_line
);
	reg        listen_r = 1'b1;
	reg        par_on_r = 1'b0;
	reg  [9:0] frame_r = 10'h0;
	integer    i;
	integer    k;
	event      got;

	initial
		o_line = 1'b1;

	always
	begin
		@(negedge i_line);
		frame_r = 10'h0;
		repeat (8) @(negedge i_clk_sys);
		for (i = 0; i < 9 + par_on_r; i = i + 1)
		begin
			repeat (16) @(negedge i_clk_sys);
			frame_r[i] = i_line;
		end
		if (listen_r)
			-> got;
	end

	// frame out
	// Low stop bit kept short so no false start follows
	task send(input [7:0] d, input p, input s, input pon);
		begin
			for (k = 0; k < 10 + pon; k = k + 1)
			begin
				o_line <= (k == 0) ? 1'b0 : (k < 9) ? d[k-1] : (k == 9 && pon) ? p : s;
				repeat ((k == 9 + pon && !s) ? 10 : 16) @(posedge i_clk_sys);
			end
			o_line <= 1'b1;
			repeat (16) @(posedge i_clk_sys);
		end
	endtask

	task pulse(input integer n);
		begin
			o_line <= 1'b0;
			repeat (n) @(posedge i_clk_sys);
			o_line <= 1'b1;
			repeat (200) @(posedge i_clk_sys);
		end
	endtask
endmodule

/* bench/dbu_top_bench.sv */
`timescale 1ns/1ps
`include "dbu_defs.vh"

// ==========================================
// Bench top
module dbu_top_bench;
	reg         clk;
	reg         resetn;
	reg  [8:0]  addr;
	reg         rd;
	reg         wr;
	reg  [31:0] wdata;
	reg  [3:0]  be;
	wire [31:0] rdata;
	wire        waitreq;
	wire        rx_pin;
	wire        tx_pin;
	wire        rx_dma;
	wire        tx_dma;
	integer     seed = 21472;
	integer     error_cnt = 0;
	integer     comparisons = 0;
	integer     cyc = 0;
	integer     k;
	reg  [2:0]  p;
	reg  [7:0]  d;
	reg  [9:0]  f;
	reg  [31:0] exp_q[$];
	reg  [31:0] msk_q[$];
	reg  [9:0]  ser_q[$];

	dbu_top dut_u
	(
		.i_clk_sys        (clk),
		.i_resetn         (resetn),
		.i_avs_address    (addr),
		.i_avs_read       (rd),
		.i_avs_write      (wr),
		.i_avs_writedata  (wdata),
		.i_avs_byteenable (be),
		.o_avs_readdata   (rdata),
		.o_avs_waitrequest(waitreq),
		.i_serial_rx_pin  (rx_pin),
		.o_serial_tx_pin  (tx_pin),
		.o_rx_dma_req     (rx_dma),
		.o_tx_dma_req     (tx_dma)
	);
	dbu_host host_u
	(
		.i_clk_sys(clk),
		.i_line   (tx_pin),
		.o_line   (rx_pin)
	);

	initial
	begin
		clk = 1'b0;
		forever
			#2.5 clk = ~clk;
	end

	function [9:0] frame_of(input [7:0] v, input [2:0] t);
		frame_of = t[2] ? {2'b01, v} : {1'b1, t[1] ? t[0] : ^v ^ t[0], v};
	endfunction

	task cmp_word(input [31:0] g, input [31:0] e, input [31:0] m);
		begin
			comparisons = comparisons + 1;
			if ((g & m) !== (e & m))
			begin
				error_cnt = error_cnt + 1;
				$display("Error at %0t: word %h, expected %h", $time, g, e);
			end
		end
	endtask

	task cmp_ser(input [9:0] g, input [9:0] e);
		begin
			comparisons = comparisons + 1;
			if (g !== e)
			begin
				error_cnt = error_cnt + 1;
				$display("Error at %0t: frame %h, expected %h", $time, g, e);
			end
		end
	endtask

	task stop_test;
		begin
			$display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
			if (error_cnt == 0 && comparisons > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask

	// Request held until wait request is seen low
	task bus(input w, input [8:0] a, input [31:0] v, input [31:0] m);
		begin
			rd <= !w;
			wr <= w;
			addr <= a;
			wdata <= v;
			if (!w)
			begin
				exp_q.push_back(v);
				msk_q.push_back(m);
			end
			@(posedge clk);
			while (waitreq !== 1'b0)
				@(posedge clk);
			rd <= 1'b0;
			wr <= 1'b0;
			@(posedge clk);
		end
	endtask

	task cmd(input [31:0] v);
		bus(1'b1, `DBU_OFS_CMD, v, 32'h0);
	endtask

	task fmt(input [31:0] v);
		bus(1'b1, `DBU_OFS_FMT, v, 32'h0);
	endtask

	task flags(input [31:0] v, input [31:0] m);
		bus(1'b0, `DBU_OFS_FLAG, v, m);
	endtask

	task rxh(input [7:0] v);
		bus(1'b0, `DBU_OFS_RXH, {24'h0, v}, 32'hff);
	endtask

	task tx_char;
		begin
			d = $random(seed);
			ser_q.push_back(frame_of(d, p));
			bus(1'b1, `DBU_OFS_TXH, {24'h0, d}, 32'h0);
		end
	endtask

	task wait_ser;
		begin
			while (ser_q.size() != 0)
				@(posedge clk);
			repeat (12) @(posedge clk);
		end
	endtask

	always @(posedge clk)
		if (rd && waitreq === 1'b0)
			cmp_word(rdata, exp_q.pop_front(), msk_q.pop_front());

	always @(host_u.got)
		cmp_ser(host_u.frame_r, ser_q.pop_front());

	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt = error_cnt + 1;
			stop_test;
		end
	end

	initial
	begin
		resetn = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 9'h0;
		wdata = 32'h0;
		be = 4'hf;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		flags(32'h0, 32'h2e3);
		bus(1'b0, `DBU_OFS_DIV, 32'h0, 32'hffffffff);
		cmd(32'h50);
		host_u.send(8'h5a, 1'b0, 1'b1, 1'b1);
		flags(32'h0, 32'h1);
		bus(1'b1, `DBU_OFS_DIV, 32'h1, 32'h0);
		for (k = 0; k < 8; k = k + 1)
		begin
			p = k;
			host_u.par_on_r = !p[2];
			fmt({p, 9'h0});
			tx_char;
			d = $random(seed);
			f = frame_of(d, p);
			host_u.send(d, f[8], 1'b1, !p[2]);
			flags(32'h203, 32'h2e3);
			cmp_word({31'h0, rx_dma}, 32'h1, 32'h1);
			rxh(d);
		end
		tx_char;
		flags(32'h2, 32'h202);
		tx_char;
		flags(32'h0, 32'h2);
		cmp_word({31'h0, tx_dma}, 32'h0, 32'h1);
		cmd(32'h80);
		wait_ser;
		flags(32'h0, 32'h202);
		cmd(32'h40);
		bus(1'b1, `DBU_OFS_DIV, 32'h2, 32'h0);
		host_u.listen_r = 1'b0;
		bus(1'b1, `DBU_OFS_TXH, 32'h0, 32'h0);
		repeat (60) @(posedge clk);
		cmd(32'h08);
		repeat (400) @(posedge clk);
		host_u.listen_r = 1'b1;
		flags(32'h0, 32'h202);
		bus(1'b1, `DBU_OFS_DIV, 32'h1, 32'h0);
		cmd(32'h40);
		fmt(32'h0);
		host_u.par_on_r = 1'b1;
		d = $random(seed);
		f = frame_of(d, 3'h0);
		host_u.send(d, !f[8], 1'b1, 1'b1);
		flags(32'h81, 32'he1);
		rxh(d);
		host_u.send(d, f[8], 1'b0, 1'b1);
		flags(32'hc1, 32'he1);
		host_u.send(d, f[8], 1'b1, 1'b1);
		flags(32'he1, 32'he1);
		cmd(32'h100);
		flags(32'h01, 32'he1);
		rxh(d);
		host_u.par_on_r = 1'b0;
		fmt(32'h800);
		host_u.pulse(7);
		flags(32'h0, 32'h1);
		host_u.pulse(8);
		rxh(8'hff);
		fork
			host_u.send(8'h3c, 1'b0, 1'b1, 1'b0);
			begin
				repeat (60) @(posedge clk);
				cmd(32'h04);
			end
		join
		flags(32'h0, 32'h1);
		cmd(32'h10);
		fork
			host_u.send(8'hc3, 1'b0, 1'b1, 1'b0);
			begin
				repeat (60) @(posedge clk);
				cmd(32'h20);
			end
		join
		rxh(8'hc3);
		host_u.send(8'h3c, 1'b0, 1'b1, 1'b0);
		flags(32'h0, 32'h1);
		cmd(32'h10);
		fmt(32'h8800);
		fork
			host_u.send(8'h00, 1'b0, 1'b1, 1'b0);
			bus(1'b1, `DBU_OFS_TXH, {24'h0, d}, 32'h0);
		join
		rxh(d);
		fmt(32'h4800);
		d = $random(seed);
		ser_q.push_back({2'b01, d});
		host_u.send(d, 1'b0, 1'b1, 1'b0);
		rxh(d);
		fmt(32'hc800);
		d = $random(seed);
		ser_q.push_back({2'b01, d});
		host_u.send(d, 1'b0, 1'b1, 1'b0);
		flags(32'h0, 32'h1);
		be <= 4'h1;
		fmt(32'hffffffff);
		be <= 4'hf;
		bus(1'b0, `DBU_OFS_FMT, 32'hc800, 32'hffffffff);
		fmt(32'h0);
		for (k = 0; k < 3; k = k + 1)
			bus(1'b0, k == 0 ? `DBU_OFS_DMA : k == 1 ? 9'h1fc : `DBU_OFS_CMD, 0, ~0);
		stop_test;
	end
endmodule
